// >>> verilog/fault_latch_defs.svh
// Timing constants of the gate driver fault latch.
// Assumes a 100 MHz system clock; counts derive from times in their own units.
`ifndef FAULT_LATCH_DEFS_SVH
`define FAULT_LATCH_DEFS_SVH
`define CLK_PERIOD_NS 10
`define CLEAR_HOLD_US 9
`define CLEAR_HOLD_CYC ((`CLEAR_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_OLD_MS 130
`define POR_NEW_MS 150
`define POR_OLD_CYC ((`POR_OLD_MS * 1000000) / `CLK_PERIOD_NS)
`define POR_NEW_CYC ((`POR_NEW_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// >>> verilog/fault_latch_pkg.sv
// Types shared by the gate driver fault latch.
// Assumes the defs header supplies all numeric constants.
package fault_latch_pkg;
  // Fault sources seen by the latch, one bit each
  typedef struct packed {
    logic overcurrent_trip;
    logic shoot_through;
    logic over_temp;
    logic supply_undervolt;
    logic dc_link_overvolt;
  } fault_src_s;
  // Command pair from the controller
  typedef struct packed {
    logic upper_switch_cmd;
    logic lower_switch_cmd;
  } switch_cmd_s;
  typedef enum logic [1:0] {
    ST_POR,
    ST_RUN,
    ST_LATCHED
  } latch_state_e;
endpackage

// >>> verilog/gate_driver_fault_latch.sv
// Fault supervision and error latch of a half-bridge gate driver.
// Assumes fault detector levels and commands are synchronous to clk_sys.
// Functional notes
// RQ1: Any supervised fault sets the error latch and raises the fault flag.
// RQ2: While latched, controller commands are ignored and both switches stay off.
// RQ3: Latch clears only with no fault and all commands low for 9 us.
// RQ4: Fault flag is open collector; low means no error.
// RQ5: A fault indication lasts at least 9 us.
// RQ6: Power-on reset completes within 130 ms or 150 ms by generation.
// RQ7: Controller keeps commands inactive until power-on reset has finished.
// RQ8: Over-current above 125 percent switches both off and latches a fault.
// RQ9: Saturation monitoring flags shoot-through as a fault.
// RQ10: Over-temperature latches a fault and raises thermal and fault flags.
// RQ11: Internal 15 V under-voltage latches a fault.
// RQ12: DC link over-voltage latches a fault.
// RQ13: Both commands high turns both outputs off without a fault.
// RQ14: Fault flag mirrors the latch until the clear condition is met.
`timescale 1ns/10ps
`default_nettype none
`include "fault_latch_defs.svh"
module gate_driver_fault_latch
  import fault_latch_pkg::*;
#(
  parameter int unsigned CLEAR_CYC = `CLEAR_HOLD_CYC,
  parameter int unsigned POR_OLD_CYC = `POR_OLD_CYC,
  parameter int unsigned POR_NEW_CYC = `POR_NEW_CYC,
  parameter int unsigned CW = 24
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic newer_generation,
  input wire fault_src_s fault_src,
  input wire switch_cmd_s switch_cmd,
  output logic upper_gate_on,
  output logic lower_gate_on,
  output logic fault_flag_oe,
  output logic fault_flag_o,
  output logic thermal_flag_oe,
  output logic thermal_flag_o,
  output logic por_done
);

  latch_state_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic gen_q, gen_d;
  logic thermal_q, thermal_d;
  logic upper_q, upper_d, lower_q, lower_d;
  logic any_fault, cmds_low;
  logic [CW-1:0] por_len;

  // Any single source is enough; in ST_POR a fault is only sampled on the last power-on reset cycle
  assign any_fault = |fault_src; // RQ9
  assign cmds_low = ~switch_cmd.upper_switch_cmd & ~switch_cmd.lower_switch_cmd;
  // Length of power-on reset follows the strap caught after release
  assign por_len = gen_q ? CW'(POR_NEW_CYC) : CW'(POR_OLD_CYC);

  // Latch sequencing; faults win over the clear in the same cycle
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    gen_d = gen_q;
    thermal_d = thermal_q;
    unique case (state_q)
      ST_POR: begin
        // Generation strap caught on the first enabled cycle after release
        if (cnt_q == '0) begin
          gen_d = newer_generation;
        end
        cnt_d = cnt_q + CW'(1);
        if (cnt_q >= por_len - CW'(1)) begin // RQ6
          cnt_d = '0;
          state_d = any_fault ? ST_LATCHED : ST_RUN;
          thermal_d = fault_src.over_temp;
        end
      end
      ST_RUN: begin
        if (any_fault) begin // RQ1
          state_d = ST_LATCHED;
          cnt_d = '0;
          thermal_d = fault_src.over_temp; // RQ10
        end
      end
      ST_LATCHED: begin
        if (fault_src.over_temp) begin
          thermal_d = 1'b1;
        end
        // Clear timer restarts on any fault or any high command
        if (any_fault || !cmds_low) begin // RQ3
          cnt_d = '0;
        end else if (cnt_q >= CW'(CLEAR_CYC) - CW'(1)) begin // RQ5
          cnt_d = '0;
          state_d = ST_RUN;
          thermal_d = 1'b0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
    endcase
  end

  // Gate outputs; fault sources gate the next value directly so switches drop at the next enabled edge
  always_comb begin
    upper_d = 1'b0;
    lower_d = 1'b0;
    if (state_q == ST_RUN && !any_fault) begin // RQ2 RQ8 RQ11 RQ12
      if (!(switch_cmd.upper_switch_cmd && switch_cmd.lower_switch_cmd)) begin // RQ13
        upper_d = switch_cmd.upper_switch_cmd;
        lower_d = switch_cmd.lower_switch_cmd;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_POR;
      cnt_q <= '0;
      gen_q <= 1'b0;
      thermal_q <= 1'b0;
      upper_q <= 1'b0;
      lower_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gen_q <= gen_d;
      thermal_q <= thermal_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
    end
  end

  assign upper_gate_on = upper_q;
  assign lower_gate_on = lower_q;
  assign por_done = (state_q != ST_POR);
  // Open collector: transistor off (released) signals a fault, so a broken wire reads high
  assign fault_flag_o = 1'b0;
  assign fault_flag_oe = (state_q == ST_RUN); // RQ4 RQ14
  assign thermal_flag_o = 1'b0;
  assign thermal_flag_oe = ~thermal_q;

  // Checker helpers, counted apart from the latch so the assertions below
  // do not merely restate the sequencing logic
  logic [CW-1:0] quiet_q, quiet_d;
  logic [CW-1:0] flag_len_q, flag_len_d;

  // Quiet cycles: no fault and both commands low; saturates instead of wrapping
  always_comb begin
    quiet_d = quiet_q;
    if (any_fault || !cmds_low) begin
      quiet_d = '0;
    end else if (quiet_q != '1) begin
      quiet_d = quiet_q + CW'(1);
    end
  end

  // Enabled cycles the fault indication has stood so far
  always_comb begin
    flag_len_d = flag_len_q;
    if (fault_flag_oe) begin
      flag_len_d = '0;
    end else if (flag_len_q != '1) begin
      flag_len_d = flag_len_q + CW'(1);
    end
  end

  // Helpers freeze with the rest of the state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quiet_q <= '0;
      flag_len_q <= '0;
    end else if (clk_en) begin
      quiet_q <= quiet_d;
      flag_len_q <= flag_len_d;
    end
  end

  a_latch_sets: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
    (clk_en && state_q == ST_RUN && any_fault) |=> state_q == ST_LATCHED)
    else $error("fault did not set latch");
  a_latched_off: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ2
    (state_q == ST_LATCHED) |=> (!upper_gate_on && !lower_gate_on))
    else $error("switch on while latched");
  a_clear_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
    (state_q == ST_LATCHED && state_d == ST_RUN && clk_en) |-> (cnt_q == CW'(CLEAR_CYC) - CW'(1) && cmds_low))
    else $error("latch cleared early");
  a_flag_mirror: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ14
    (!fault_flag_oe && state_q != ST_POR && (any_fault || !cmds_low)) |=> !fault_flag_oe)
    else $error("fault flag dropped before clear");
  a_flag_min: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ5
    ($rose(fault_flag_oe) && $past(state_q) == ST_LATCHED) |-> flag_len_q >= CW'(CLEAR_CYC))
    else $error("fault pulse too short");
  a_fault_off: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ8
    (clk_en && fault_src.overcurrent_trip) |=> (!upper_gate_on && !lower_gate_on))
    else $error("switch on during overcurrent");
  a_thermal_flag: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
    (clk_en && state_q == ST_RUN && fault_src.over_temp) |=> (!thermal_flag_oe && !fault_flag_oe))
    else $error("thermal flags not raised");
  a_both_high: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ13
    (clk_en && state_q == ST_RUN && !any_fault && switch_cmd.upper_switch_cmd && switch_cmd.lower_switch_cmd)
    |=> (!upper_gate_on && !lower_gate_on && state_q == ST_RUN))
    else $error("both high mishandled");
  a_por_off: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ6
    (state_q == ST_POR) |=> (!upper_gate_on && !lower_gate_on))
    else $error("switch on during power-on reset");
  a_flag_raise: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
    (clk_en && any_fault) |=> !fault_flag_oe)
    else $error("fault flag not raised");
  a_clear_quiet: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
    (state_q == ST_LATCHED) ##1 (state_q == ST_RUN) |-> quiet_q >= CW'(CLEAR_CYC))
    else $error("latch cleared without full quiet time");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
    (clk_en && state_q == ST_LATCHED && (any_fault || !cmds_low)) |=> state_q == ST_LATCHED)
    else $error("latch left while clear condition broken");
  a_run_cool: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
    (state_q == ST_RUN) |-> thermal_flag_oe)
    else $error("thermal flag shown while running");
  a_gate_exclusive: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ13
    !(upper_gate_on && lower_gate_on))
    else $error("both switches on");

endmodule
`default_nettype wire

// >>> dv/ctrl_model.sv
// Controller model: sends switch commands and reads the fault lines.
// Assumes flag pull-ups sit on the controller side.
`timescale 1ns/10ps
`default_nettype none
module ctrl_model
  import fault_latch_pkg::*;
(
  input wire logic por_done,
  input wire switch_cmd_s cmd_req,
  input wire logic fault_flag_oe,
  input wire logic fault_flag_o,
  input wire logic thermal_flag_oe,
  input wire logic thermal_flag_o,
  output var switch_cmd_s switch_cmd,
  output logic fault_line,
  output logic thermal_line
);
  // No switching until power-on reset ends
  assign switch_cmd = por_done ? cmd_req : '0;
  // Released line reads high through the pull-up
  assign fault_line = fault_flag_oe ? fault_flag_o : 1'b1;
  assign thermal_line = thermal_flag_oe ? thermal_flag_o : 1'b1;
endmodule
`default_nettype wire

// >>> dv/gate_driver_fault_latch_bench.sv
// Bench for the fault latch with a controller model.
// Assumes short POR and clear counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
module gate_driver_fault_latch_bench;
  import fault_latch_pkg::*;
  localparam int CLR = 10;
  localparam int POR_OLD = 20, POR_NEW = 30;
  logic clk_sys = 0, rstn = 0, gen = 0, en = 1, up, lo, f_oe, f_o, t_oe, t_o, por_done, f_line, t_line;
  fault_src_s fault_src = '0;
  switch_cmd_s cmd_req = '0, switch_cmd, prev;
  int n_errors = 0, n_tests = 0, cyc = 0, k, i, n, last;
  always #5 clk_sys = ~clk_sys;
  gate_driver_fault_latch #(.CLEAR_CYC(CLR), .POR_OLD_CYC(POR_OLD), .POR_NEW_CYC(POR_NEW)) gate_driver_fault_latch_i (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(en), .newer_generation(gen), .fault_src(fault_src),
    .switch_cmd(switch_cmd), .upper_gate_on(up), .lower_gate_on(lo), .fault_flag_oe(f_oe),
    .fault_flag_o(f_o), .thermal_flag_oe(t_oe), .thermal_flag_o(t_o), .por_done(por_done));
  ctrl_model ctrl_model_i (.por_done(por_done), .cmd_req(cmd_req), .fault_flag_oe(f_oe),
    .fault_flag_o(f_o), .thermal_flag_oe(t_oe), .thermal_flag_o(t_o), .switch_cmd(switch_cmd),
    .fault_line(f_line), .thermal_line(t_line));
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cmp_gates(input logic [1:0] exp);
    n_tests++;
    if ({up, lo} !== exp) begin
      n_errors++;
      $display("[ERR] %0t gates %b exp %b", $time, {up, lo}, exp);
    end
  endtask
  // Both commands high means both off, never a fault
  function automatic logic [1:0] exp_gates(input switch_cmd_s c);
    return (c.upper_switch_cmd & c.lower_switch_cmd) ? 2'b00 : c;
  endfunction
  task automatic report_and_stop();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset, then time the power-on interval of the chosen generation
  task automatic do_reset(input logic g);
    rstn <= 1'b0;
    gen <= g;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    n = 0;
    #1 cmp_bit(f_line, 1'b1);
    cmp_bit(t_line, 1'b0);
    cmp_gates(2'b00);
    while (por_done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    cmp_bit(n == (g ? POR_NEW : POR_OLD), 1'b1);
    @(posedge clk_sys);
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(69));
    do_reset(1'b1);
    do_reset(1'b0);
    // Commands pass one cycle later; the 11 corner leads
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      prev = switch_cmd;
      cmd_req <= (k < 2) ? 2'b11 : switch_cmd_s'($urandom);
      #1 cmp_gates(exp_gates(prev));
      cmp_bit(f_line, 1'b0);
    end
    // Each fault source latches, blocks commands and holds the flag
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      fault_src <= fault_src_s'(5'h01 << i);
      @(posedge clk_sys);
      fault_src <= '0;
      #1 cmp_bit(f_line, 1'b1);
      cmp_bit(t_line, i == 2);
      n = 1;
      last = 1;
      for (k = 0; k < 6; k++) begin
        @(posedge clk_sys);
        // Command seen at this edge restarts the clear time
        if (cmd_req != '0) last = k + 2;
        cmd_req <= (k < 5) ? switch_cmd_s'($urandom) : '0;
        #1 cmp_gates(2'b00);
        cmp_bit(f_line, 1'b1);
        n++;
      end
      while (f_line === 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1 n++;
      end
      cmp_bit(n == last + CLR, 1'b1);
      @(posedge clk_sys);
      cmd_req <= 2'b10;
      repeat (2) @(posedge clk_sys);
      cmd_req <= '0;
      #1 cmp_gates(2'b10);
      cmp_bit(t_line, 1'b0);
    end
    // Clock enable low freezes gates and latch; a fault meanwhile is not taken
    @(posedge clk_sys);
    en <= 1'b0;
    cmd_req <= 2'b01;
    fault_src <= fault_src_s'(5'h10);
    repeat (3) @(posedge clk_sys);
    en <= 1'b1;
    fault_src <= '0;
    #1 cmp_gates(2'b00);
    cmp_bit(f_line, 1'b0);
    repeat (2) @(posedge clk_sys);
    cmd_req <= '0;
    #1 cmp_gates(2'b01);
    report_and_stop();
  end
endmodule
`default_nettype wire
